// >>> shared/tct_pkg.sv
package tct_pkg;
  // channel and counter geometry
  localparam int          TCT_NCH       = 3;
  localparam int          TCT_CW        = 16;
  localparam logic [15:0] TCT_CNT_RST   = 16'h0000;
  localparam logic [15:0] TCT_CNT_MAX   = 16'hffff;
  localparam logic [15:0] TCT_RC_RST    = 16'h0000;
  // clock source select codes (3-bit field)
  localparam logic [2:0]  TCT_CLK_INT1  = 3'h0;
  localparam logic [2:0]  TCT_CLK_INT5  = 3'h4;
  localparam logic [2:0]  TCT_CLK_XC0   = 3'h5;
  // burst gate codes: 0 none, 1..3 ext_clk_in0..2
  localparam logic [1:0]  TCT_BURST_OFF = 2'h0;
  // block mode routing: 0 pin, 1 other channel line a
  localparam logic        TCT_ROUTE_PIN = 1'b0;
  // capture-mode ext trigger select: 0 line b, 1 line a
  localparam logic        TCT_ABTRG_B   = 1'b0;
  // waveform ext event select: 0 line b, 1..3 ext_clk_in0..2
  localparam logic [1:0]  TCT_EEVT_B    = 2'h0;
  // edge select: 0 none, 1 rising, 2 falling, 3 both
  localparam logic [1:0]  TCT_EDGE_NONE = 2'h0;
  localparam logic [1:0]  TCT_EDGE_RISE = 2'h1;
  localparam logic [1:0]  TCT_EDGE_FALL = 2'h2;
  // prescaler divide exponents for the five internal clocks
  localparam int          TCT_DIV1_LOG  = 1;
  localparam int          TCT_DIV2_LOG  = 3;
  localparam int          TCT_DIV3_LOG  = 5;
  localparam int          TCT_DIV4_LOG  = 7;
  localparam int          TCT_DIV5_LOG  = 10;
  localparam int          TCT_PRE_W     = 10;
  // channel run state
  typedef enum logic [2:0] {
    TCT_ST_OFF  = 3'b001,
    TCT_ST_STOP = 3'b010,
    TCT_ST_RUN  = 3'b100
  } tct_state_t;
endpackage

// >>> src/tct_core.sv
`timescale 1ns/1ps
// Operation
// RULE_01 - three identical channels, 16-bit up-counters
// RULE_02 - each channel drives own interrupt output
// RULE_03 - count selected edge, overflow sets flag
// RULE_04 - live count readable any time
// RULE_05 - trigger clears counter on next edge
// RULE_06 - block mode routes pins or chained lines
// RULE_07 - select five internal or three external
// RULE_08 - invert bit counts on opposite edge
// RULE_09 - burst gate validates clock while high
// RULE_10 - external clocks slower than 2.5x master
// RULE_11 - enable and disable commands control clock
// RULE_12 - b load or compare auto-disables
// RULE_13 - disabled clock ignores start and stop
// RULE_14 - enabled flag mirrors clock enable
// RULE_15 - any trigger starts an enabled clock
// RULE_16 - b load or compare stops clock
// RULE_17 - waveform bit selects capture or waveform
// RULE_18 - capture mode: lines a, b inputs
// RULE_19 - waveform: a output, b unless event
// RULE_20 - soft trigger bit triggers channel
// RULE_21 - block sync triggers all channels
// RULE_22 - compare trigger enable: match triggers
// RULE_23 - ext trigger source per mode, enabled
// RULE_24 - external trigger pulses exceed one period
// RULE_25 - disable wins over simultaneous enable
module tct_core
  import tct_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // block-level controls
  input  wire logic        block_sync,
  input  wire logic [2:0]  block_route,
  input  wire logic [2:0]  ext_clk_pin,
  // per-channel control writes (pulses)
  input  wire logic [2:0]  clk_enable_cmd,
  input  wire logic [2:0]  clk_disable_cmd,
  input  wire logic [2:0]  soft_trigger,
  // per-channel mode fields
  input  wire logic [8:0]  clk_source_sel,
  input  wire logic [2:0]  clk_invert,
  input  wire logic [5:0]  burst_sel,
  input  wire logic [2:0]  wave_mode,
  input  wire logic [2:0]  load_b_disable,
  input  wire logic [2:0]  load_b_stop,
  input  wire logic [2:0]  compare_c_disable,
  input  wire logic [2:0]  compare_c_stop,
  input  wire logic [2:0]  compare_c_trigger_en,
  input  wire logic [2:0]  ext_event_trigger_en,
  input  wire logic [2:0]  ext_trig_line_a,
  input  wire logic [5:0]  ext_event_sel,
  input  wire logic [5:0]  ext_edge_sel,
  input  wire logic [47:0] compare_c_val,
  input  wire logic [2:0]  capture_b_load,
  input  wire logic [2:0]  overflow_clr,
  input  wire logic [2:0]  irq_enable,
  // i/o lines: input, output, output enable (low = driven)
  input  wire logic [2:0]  io_line_a_in,
  input  wire logic [2:0]  io_line_b_in,
  input  wire logic [2:0]  io_line_a_out_val,
  input  wire logic [2:0]  io_line_b_out_val,
  output logic      [2:0]  io_line_a_out,
  output logic      [2:0]  io_line_a_oe_n,
  output logic      [2:0]  io_line_b_out,
  output logic      [2:0]  io_line_b_oe_n,
  // status
  output logic      [47:0] counter_value,
  output logic      [2:0]  counter_overflow_flag,
  output logic      [2:0]  clk_enabled_flag,
  output logic      [2:0]  running_flag,
  output logic      [2:0]  chan_irq
);

  // pin synchronisers, two stages each
  logic [2:0] pin_s1_q, pin_s2_q;
  logic [2:0] ioa_s1_q, ioa_s2_q;
  logic [2:0] iob_s1_q, iob_s2_q;
  // shared prescaler
  logic [TCT_PRE_W-1:0] pre_q;
  logic [4:0] int_tick;

  // two-flop synchronisers for pins and io lines
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      ioa_s1_q <= 3'h0;
      ioa_s2_q <= 3'h0;
      iob_s1_q <= 3'h0;
      iob_s2_q <= 3'h0;
    end else if (ce) begin
      pin_s1_q <= ext_clk_pin;
      pin_s2_q <= pin_s1_q;
      ioa_s1_q <= io_line_a_in;
      ioa_s2_q <= ioa_s1_q;
      iob_s1_q <= io_line_b_in;
      iob_s2_q <= iob_s1_q;
    end
  end

  // free-running prescaler for internal clocks
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_q <= '0;
    end else if (ce) begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // internal clock ticks: one-cycle pulses at each divided rate
  assign int_tick[0] = &pre_q[TCT_DIV1_LOG-1:0];
  assign int_tick[1] = &pre_q[TCT_DIV2_LOG-1:0];
  assign int_tick[2] = &pre_q[TCT_DIV3_LOG-1:0];
  assign int_tick[3] = &pre_q[TCT_DIV4_LOG-1:0];
  assign int_tick[4] = &pre_q[TCT_DIV5_LOG-1:0];

  // line a level each channel sees (own output or pin input)
  logic [2:0] line_a_lvl;
  // routed external clocks ext_clk_in0..2, same for every channel
  logic [2:0] ext_clk_in;

  // line a is the driven value in waveform mode
  assign line_a_lvl = (wave_mode & io_line_a_out) | (~wave_mode & ioa_s2_q);

  // RULE_06 block routing
  // input k takes its pin or line a of neighbour channel
  assign ext_clk_in[0] = (block_route[0] == TCT_ROUTE_PIN) ? pin_s2_q[0]
                       : line_a_lvl[1];
  assign ext_clk_in[1] = (block_route[1] == TCT_ROUTE_PIN) ? pin_s2_q[1]
                       : line_a_lvl[2];
  assign ext_clk_in[2] = (block_route[2] == TCT_ROUTE_PIN) ? pin_s2_q[2]
                       : line_a_lvl[0];

  // RULE_01 three channels
  // one generate loop builds every channel
  for (genvar c = 0; c < TCT_NCH; c++) begin : g_ch
    logic [2:0]        sel;       // clock source code
    logic [1:0]        bsel;      // burst gate code
    logic [1:0]        esel;      // ext event code
    logic [1:0]        edg;       // ext edge code
    logic [15:0]       rc;        // compare value
    logic              clk_lvl;   // selected clock level after invert
    logic              clk_lvl_q; // previous level for edge detect
    logic              gate;      // burst gate allows counting
    logic              tick;      // one active counting edge
    logic              ev_lvl;    // chosen ext trigger level
    logic              ev_q;      // previous ext trigger level
    logic              ev_hit;    // ext edge seen
    logic              match;     // counter equals compare
    logic              trig;      // any trigger this cycle
    logic              pend_q;    // trigger waiting for clock edge
    logic              dis_ev;    // automatic disable event
    logic              stop_ev;   // stop event
    logic [TCT_CW-1:0] cnt_q;     // counter
    tct_state_t        st_q;      // run state
    logic              ovf_q;     // overflow flag
    logic              cmp_hit;   // compare match on a running tick
    logic              atrg;      // triggers that wait for a tick
    logic              ctrg;      // compare trigger on this tick

    assign sel  = clk_source_sel[3*c +: 3];
    assign bsel = burst_sel[2*c +: 2];
    assign esel = ext_event_sel[2*c +: 2];
    assign edg  = ext_edge_sel[2*c +: 2];
    assign rc   = compare_c_val[16*c +: 16];

    // RULE_07 source select
    // codes 0..4 internal ticks, 5..7 external inputs
    always_comb begin
      clk_lvl = 1'b0;
      if (sel <= TCT_CLK_INT5) begin
        clk_lvl = int_tick[sel - TCT_CLK_INT1];
      end else begin
        clk_lvl = ext_clk_in[2'(sel - TCT_CLK_XC0)];
      end
      // RULE_08 invert edge
      clk_lvl = clk_lvl ^ clk_invert[c];
    end

    // RULE_09 burst gate
    assign gate = (bsel == TCT_BURST_OFF) | ext_clk_in[2'(bsel - 2'h1)];

    // RULE_10 slow external clock
    // one rising edge per sampled level change needs slow inputs
    assign tick = clk_lvl & ~clk_lvl_q & gate;

    // RULE_23 trigger source
    // capture: line a or b; waveform: line b or ext inputs
    always_comb begin
      ev_lvl = iob_s2_q[c];
      if (!wave_mode[c]) begin
        ev_lvl = ext_trig_line_a[c] ? ioa_s2_q[c] : iob_s2_q[c];
      end else if (esel != TCT_EEVT_B) begin
        ev_lvl = ext_clk_in[2'(esel - 2'h1)];
      end
    end

    // RULE_24 pulse width
    // edge detector on synchronised level catches pulses over a period
    always_comb begin
      case (edg)
        TCT_EDGE_NONE: ev_hit = 1'b0;
        TCT_EDGE_RISE: ev_hit = ev_lvl & ~ev_q;
        TCT_EDGE_FALL: ev_hit = ~ev_lvl & ev_q;
        default:       ev_hit = ev_lvl ^ ev_q;
      endcase
    end

    assign match = (cnt_q == rc);
    // compare events only count on a tick of a running counter
    assign cmp_hit = match & tick & (st_q == TCT_ST_RUN);

    // RULE_20 soft trigger
    // RULE_21 block sync
    // triggers that wait for the next counting tick
    assign atrg = soft_trigger[c] | block_sync
                | (ev_hit & (~wave_mode[c] | ext_event_trigger_en[c]));
    // RULE_22 compare trigger
    // a match clears on the tick that leaves the compare value
    assign ctrg = compare_c_trigger_en[c] & cmp_hit;
    assign trig = atrg | ctrg;

    // RULE_12 auto disable
    assign dis_ev = wave_mode[c] ? (compare_c_disable[c] & cmp_hit)
                                 : (load_b_disable[c] & capture_b_load[c]);
    // RULE_16 auto stop
    assign stop_ev = wave_mode[c] ? (compare_c_stop[c] & cmp_hit)
                                  : (load_b_stop[c] & capture_b_load[c]);

    // edge-detect history registers
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        clk_lvl_q <= 1'b0;
        ev_q      <= 1'b0;
      end else if (ce) begin
        clk_lvl_q <= clk_lvl;
        ev_q      <= ev_lvl;
      end
    end

    // clock control state machine
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        st_q <= TCT_ST_OFF;
      end else if (ce) begin
        case (st_q)
          TCT_ST_OFF: begin
            // RULE_25 disable priority
            // RULE_13 only enable leaves off
            if (clk_enable_cmd[c] & ~clk_disable_cmd[c]) begin
              st_q <= TCT_ST_STOP;
            end
          end
          TCT_ST_STOP, TCT_ST_RUN: begin
            // RULE_11 disable command
            if (clk_disable_cmd[c] | dis_ev) begin
              st_q <= TCT_ST_OFF;
            // a stop event outranks a trigger on the same tick
            end else if (stop_ev) begin
              st_q <= TCT_ST_STOP;
            // RULE_15 trigger starts
            end else if (trig) begin
              st_q <= TCT_ST_RUN;
            end
          end
          default: st_q <= TCT_ST_OFF;
        endcase
      end
    end

    // pending trigger held until the next counting edge
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        pend_q <= 1'b0;
      end else if (ce) begin
        if (atrg & (st_q != TCT_ST_OFF)) begin
          pend_q <= 1'b1;
        end else if (tick) begin
          pend_q <= 1'b0;
        end
      end
    end

    // RULE_03 counting and wrap
    // RULE_05 reset on edge
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        cnt_q <= TCT_CNT_RST;
      end else if (ce && tick && (st_q == TCT_ST_RUN || pend_q)) begin
        // waiting triggers and a compare trigger clear on this tick
        cnt_q <= (pend_q | ctrg) ? TCT_CNT_RST : cnt_q + 1'b1;
      end
    end

    // overflow flag: set wins over clear
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        ovf_q <= 1'b0;
      end else if (ce) begin
        if (tick && st_q == TCT_ST_RUN && !pend_q
            && cnt_q == TCT_CNT_MAX) begin
          ovf_q <= 1'b1;
        end else if (overflow_clr[c]) begin
          ovf_q <= 1'b0;
        end
      end
    end

    // registered outputs
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        counter_value[16*c +: 16] <= TCT_CNT_RST;
        counter_overflow_flag[c]  <= 1'b0;
        clk_enabled_flag[c]       <= 1'b0;
        running_flag[c]           <= 1'b0;
        chan_irq[c]               <= 1'b0;
        io_line_a_out[c]          <= 1'b0;
        io_line_a_oe_n[c]         <= 1'b1;
        io_line_b_out[c]          <= 1'b0;
        io_line_b_oe_n[c]         <= 1'b1;
      end else if (ce) begin
        // RULE_04 live count
        counter_value[16*c +: 16] <= cnt_q;
        counter_overflow_flag[c]  <= ovf_q;
        // RULE_14 enabled flag
        clk_enabled_flag[c]       <= (st_q != TCT_ST_OFF);
        running_flag[c]           <= (st_q == TCT_ST_RUN);
        // RULE_02 channel interrupt
        chan_irq[c]               <= ovf_q & irq_enable[c];
        io_line_a_out[c]          <= io_line_a_out_val[c];
        io_line_b_out[c]          <= io_line_b_out_val[c];
        // RULE_17 mode select
        // RULE_18 capture inputs
        // RULE_19 waveform outputs
        io_line_a_oe_n[c] <= ~wave_mode[c];
        io_line_b_oe_n[c] <= ~wave_mode[c] | (esel == TCT_EEVT_B);
      end
    end
  end

endmodule // tct_core

// >>> dv/tct_chk.sv
`timescale 1ns/1ps
// watches channel 0, the disable path of channel 1 and the block-wide
// start paths
module tct_chk
  import tct_pkg::*;
(
  input logic        clk,
  input logic        rst_n,
  input logic        block_sync,
  input logic [2:0]  clk_enable_cmd,
  input logic [2:0]  clk_disable_cmd,
  input logic [2:0]  soft_trigger,
  input logic [2:0]  wave_mode,
  input logic [2:0]  load_b_stop,
  input logic [2:0]  compare_c_stop,
  input logic [5:0]  ext_event_sel,
  input logic [2:0]  irq_enable,
  input logic [2:0]  io_line_a_oe_n,
  input logic [2:0]  io_line_b_oe_n,
  input logic [47:0] counter_value,
  input logic [2:0]  counter_overflow_flag,
  input logic [2:0]  clk_enabled_flag,
  input logic [2:0]  running_flag,
  input logic [2:0]  chan_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // no disable command and no stop enable active
  sequence s_calm;
    !(|clk_disable_cmd) && !(|$past(clk_disable_cmd)) &&
      !(|compare_c_stop) && !(|load_b_stop);
  endsequence
  // enabled channel 0 gets a soft trigger
  sequence s_trig0;
    soft_trigger[0] && clk_enabled_flag[0];
  endsequence
  en_flag_a: assert property (
    clk_enable_cmd[0] && !clk_disable_cmd[0] |-> ##2 clk_enabled_flag[0])
    else $error("enable flag missing");
  dis_wins_a: assert property (
    clk_disable_cmd[1] |-> ##2 !clk_enabled_flag[1])
    else $error("disable not honoured");
  trig_start_a: assert property (
    (s_trig0 and s_calm) ##1 s_calm |-> ##1 running_flag[0])
    else $error("trigger did not start");
  sync_all_a: assert property (
    block_sync && (&clk_enabled_flag) ##0 s_calm ##1 s_calm
    |-> ##1 (&running_flag))
    else $error("sync did not start all");
  cnt_step_a: assert property (
    counter_value[15:0] != $past(counter_value[15:0]) |->
      counter_value[15:0] == $past(counter_value[15:0]) + 16'h0001 ||
      counter_value[15:0] == TCT_CNT_RST)
    else $error("counter jumped");
  wrap_flag_a: assert property (
    counter_value[15:0] == TCT_CNT_MAX ##1 counter_value[15:0] == 16'h0
    |-> ##[0:2] counter_overflow_flag[0])
    else $error("overflow flag missing");
  irq_mask_a: assert property (
    !irq_enable[0] |=> !chan_irq[0])
    else $error("masked interrupt seen");
  cap_inputs_a: assert property (
    !wave_mode[0] ##1 !wave_mode[0] |-> io_line_a_oe_n[0] && io_line_b_oe_n[0])
    else $error("capture line driven");
  wave_drive_a: assert property (
    wave_mode[0] && ext_event_sel[1:0] != TCT_EEVT_B ##1
      wave_mode[0] && ext_event_sel[1:0] != TCT_EEVT_B
    |-> !io_line_a_oe_n[0] && !io_line_b_oe_n[0])
    else $error("waveform line not driven");
endmodule // tct_chk

bind tct_core tct_chk u_tct_chk (
  .clk(clk), .rst_n(rst_n), .block_sync(block_sync),
  .clk_enable_cmd(clk_enable_cmd), .clk_disable_cmd(clk_disable_cmd),
  .soft_trigger(soft_trigger), .wave_mode(wave_mode),
  .load_b_stop(load_b_stop), .compare_c_stop(compare_c_stop),
  .ext_event_sel(ext_event_sel), .irq_enable(irq_enable),
  .io_line_a_oe_n(io_line_a_oe_n), .io_line_b_oe_n(io_line_b_oe_n),
  .counter_value(counter_value),
  .counter_overflow_flag(counter_overflow_flag),
  .clk_enabled_flag(clk_enabled_flag), .running_flag(running_flag),
  .chan_irq(chan_irq)
);

// >>> dv/tct_pin_model.sv
`timescale 1ns/1ps
// far side: clock pins and line b source, idle low
module tct_pin_model (
  input  wire logic       clk,
  output logic      [2:0] ext_clk_pin,
  output logic      [2:0] io_line_b_in
);
  initial begin
    ext_clk_pin = 3'h0;
    io_line_b_in = 3'h0;
  end
  // gate level on pin 0
  task set_gate(input logic g);
    ext_clk_pin[0] = g;
  endtask
  task clk_burst(input int n);
    repeat (n) begin
      ext_clk_pin[1] = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      ext_clk_pin[1] = 1'b0;
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  task line_b_pulse;
    io_line_b_in[2] = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    io_line_b_in[2] = 1'b0;
  endtask
endmodule // tct_pin_model

// >>> dv/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin \
  fail_count++; $display("[FAIL] %s exp %0h got %0h", nm, e, a); end end
module tb_top;
  import tct_pkg::*;
  logic        clk, rst_n, ce, block_sync;
  logic [2:0]  block_route, ext_clk_pin, clk_enable_cmd, clk_disable_cmd;
  logic [2:0]  soft_trigger, clk_invert, wave_mode, load_b_disable;
  logic [2:0]  load_b_stop, compare_c_disable, compare_c_stop;
  logic [2:0]  compare_c_trigger_en, ext_event_trigger_en, ext_trig_line_a;
  logic [2:0]  capture_b_load, overflow_clr, irq_enable, io_line_a_in;
  logic [2:0]  io_line_b_in, io_line_a_out_val, io_line_b_out_val;
  logic [2:0]  io_line_a_out, io_line_a_oe_n, io_line_b_out, io_line_b_oe_n;
  logic [2:0]  counter_overflow_flag, clk_enabled_flag, running_flag;
  logic [2:0]  chan_irq;
  logic [8:0]  clk_source_sel;
  logic [5:0]  burst_sel, ext_event_sel, ext_edge_sel;
  logic [47:0] compare_c_val, counter_value;
  logic [15:0] v0;
  int          fail_count, num_checks;
  int          lg[5] = '{TCT_DIV1_LOG, TCT_DIV2_LOG, TCT_DIV3_LOG,
                         TCT_DIV4_LOG, TCT_DIV5_LOG};
  tct_core u_tct_core (
    .clk(clk), .rst_n(rst_n), .ce(ce), .block_sync(block_sync),
    .block_route(block_route), .ext_clk_pin(ext_clk_pin),
    .clk_enable_cmd(clk_enable_cmd), .clk_disable_cmd(clk_disable_cmd),
    .soft_trigger(soft_trigger), .clk_source_sel(clk_source_sel),
    .clk_invert(clk_invert), .burst_sel(burst_sel), .wave_mode(wave_mode),
    .load_b_disable(load_b_disable), .load_b_stop(load_b_stop),
    .compare_c_disable(compare_c_disable), .compare_c_stop(compare_c_stop),
    .compare_c_trigger_en(compare_c_trigger_en),
    .ext_event_trigger_en(ext_event_trigger_en),
    .ext_trig_line_a(ext_trig_line_a), .ext_event_sel(ext_event_sel),
    .ext_edge_sel(ext_edge_sel), .compare_c_val(compare_c_val),
    .capture_b_load(capture_b_load), .overflow_clr(overflow_clr),
    .irq_enable(irq_enable), .io_line_a_in(io_line_a_in),
    .io_line_b_in(io_line_b_in), .io_line_a_out_val(io_line_a_out_val),
    .io_line_b_out_val(io_line_b_out_val), .io_line_a_out(io_line_a_out),
    .io_line_a_oe_n(io_line_a_oe_n), .io_line_b_out(io_line_b_out),
    .io_line_b_oe_n(io_line_b_oe_n), .counter_value(counter_value),
    .counter_overflow_flag(counter_overflow_flag),
    .clk_enabled_flag(clk_enabled_flag), .running_flag(running_flag),
    .chan_irq(chan_irq)
  );
  tct_pin_model u_tct_pin_model (.clk(clk), .ext_clk_pin(ext_clk_pin),
                                 .io_line_b_in(io_line_b_in));
  initial clk = 1'b0;
  always #5 clk = ~clk;
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle command pulse, then the two-edge answer time
  task automatic pulse(ref logic [2:0] s, input logic [2:0] m);
    s = m;
    cyc(1);
    s = 3'h0;
    cyc(2);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task t_enable;
    `CHK("oe_a", 3'h7, io_line_a_oe_n)
    `CHK("oe_b", 3'h7, io_line_b_oe_n)
    clk_enable_cmd = 3'h7;
    clk_disable_cmd = 3'h2;
    pulse(overflow_clr, 3'h7);
    {clk_enable_cmd, clk_disable_cmd} = '0;
    `CHK("en", 3'h5, clk_enabled_flag)
    pulse(clk_enable_cmd, 3'h2);
    `CHK("en", 3'h7, clk_enabled_flag)
    `CHK("ovf", 3'h0, counter_overflow_flag)
    irq_enable = 3'h7;
    $display("enable test done");
  endtask
  task t_count;
    pulse(soft_trigger, 3'h1);
    `CHK("run", 1'b1, running_flag[0])
    for (int i = 0; i < 5; i++) begin
      clk_source_sel[2:0] = TCT_CLK_INT1 + 3'(i);
      cyc(4);
      v0 = counter_value[15:0];
      cyc(1024);
      `CHK("ticks", v0 + 16'(1024 >> lg[i]), counter_value[15:0])
    end
    $display("count test done");
  endtask
  task t_compare;
    logic [15:0] mx;
    mx = '0;
    clk_source_sel[2:0] = TCT_CLK_INT1;
    {wave_mode[0], compare_c_trigger_en[0]} = 2'b11;
    ext_event_sel[1:0] = 2'h1;
    {io_line_a_out_val, io_line_b_out_val} = 6'h09;
    compare_c_val[15:0] = 16'h0014;
    pulse(soft_trigger, 3'h1);
    repeat (120) begin
      cyc(1);
      if (counter_value[15:0] > mx) mx = counter_value[15:0];
    end
    `CHK("cmp max", 16'h0014, mx)
    `CHK("oe_a", 1'b0, io_line_a_oe_n[0])
    `CHK("oe_b", 1'b0, io_line_b_oe_n[0])
    `CHK("out_a", 1'b1, io_line_a_out[0])
    `CHK("out_b", 1'b1, io_line_b_out[0])
    ext_event_sel[1:0] = TCT_EEVT_B;
    compare_c_stop[0] = 1'b1;
    cyc(60);
    `CHK("oe_b ev", 1'b1, io_line_b_oe_n[0])
    `CHK("stopped", 1'b0, running_flag[0])
    `CHK("still en", 1'b1, clk_enabled_flag[0])
    {compare_c_stop[0], compare_c_disable[0]} = 2'b01;
    pulse(soft_trigger, 3'h1);
    `CHK("restart", 1'b1, running_flag[0])
    cyc(60);
    `CHK("auto dis", 1'b0, clk_enabled_flag[0])
    pulse(soft_trigger, 3'h1);
    `CHK("no start", 1'b0, running_flag[0])
    {wave_mode[0], compare_c_disable[0], compare_c_trigger_en[0]} = '0;
    pulse(clk_enable_cmd, 3'h1);
    block_sync = 1'b1;
    cyc(1);
    block_sync = 1'b0;
    cyc(2);
    `CHK("sync", 3'h7, running_flag)
    $display("compare and sync test done");
  endtask
  task t_ext;
    clk_source_sel[5:3] = TCT_CLK_XC0 + 3'h1;
    burst_sel[3:2] = 2'h1;
    clk_invert[1] = 1'b1;
    cyc(8);
    v0 = counter_value[31:16];
    u_tct_pin_model.clk_burst(6);
    cyc(8);
    `CHK("gated", v0, counter_value[31:16])
    u_tct_pin_model.set_gate(1'b1);
    pulse(soft_trigger, 3'h2);
    u_tct_pin_model.clk_burst(6);
    cyc(8);
    `CHK("ext cnt", 16'h0005, counter_value[31:16])
    {block_route[1], wave_mode[2]} = 2'b11;
    cyc(4);
    pulse(soft_trigger, 3'h2);
    repeat (6) begin
      io_line_a_out_val[2] = ~io_line_a_out_val[2];
      cyc(4);
    end
    cyc(8);
    `CHK("chain", 16'h0002, counter_value[31:16])
    {block_route[1], wave_mode[2]} = 2'b00;
    $display("external clock test done");
  endtask
  task t_capture;
    ext_edge_sel[5:4] = TCT_EDGE_RISE;
    load_b_stop[2] = 1'b1;
    pulse(capture_b_load, 3'h4);
    cyc(2);
    `CHK("b stop", 1'b0, running_flag[2])
    `CHK("cap oe", 1'b1, io_line_a_oe_n[2])
    load_b_stop[2] = 1'b0;
    u_tct_pin_model.line_b_pulse();
    cyc(6);
    `CHK("ext trg", 1'b1, running_flag[2])
    load_b_disable[2] = 1'b1;
    pulse(capture_b_load, 3'h4);
    cyc(2);
    `CHK("b dis", 1'b0, clk_enabled_flag[2])
    `CHK("irq", 3'h0, chan_irq)
    $display("capture test done");
  endtask
  initial begin
    {block_route, clk_enable_cmd, clk_disable_cmd, soft_trigger} = '0;
    {clk_invert, wave_mode, load_b_disable, load_b_stop} = '0;
    {compare_c_disable, compare_c_stop, compare_c_trigger_en} = '0;
    {ext_event_trigger_en, ext_trig_line_a, capture_b_load} = '0;
    {overflow_clr, irq_enable, io_line_a_in} = '0;
    {io_line_a_out_val, io_line_b_out_val, compare_c_val} = '0;
    {clk_source_sel, burst_sel, ext_event_sel, ext_edge_sel} = '0;
    {ce, rst_n, block_sync} = 3'b100;
    cyc(12);
    rst_n = 1'b1;
    t_enable();
    t_count();
    t_compare();
    t_ext();
    t_capture();
    finish_test();
  end
endmodule // tb_top
